/* hw/aesr_status.sv */
// remote status reporting: alarm latch, standard events, status byte, service request
// assumes chars and commands from a same-clock parser; alarm and panel inputs are async pins
// Functional notes
// - 32-bit alarm latch, one bit per channel, set when its alarm trips.
// - latch bits stay set until latch read or clear-status.
// - latch read returns contents then zeroes the whole latch.
// - status bit 0 set when latch and alarm enable share a set bit.
// - status bit 5 set when event register and event enable share a bit.
// - event register read returns value then clears it.
// - event bit 7 set at power-up.
// - event bit 6 set on front panel touch.
// - event bit 5 set on command assembly failure.
// - event bit 4 set on command execution failure.
// - event bits 3, 2, 1 always read zero.
// - event bit 0 set only by operation-complete command.
// - clear-status forces every status register but macro enable to zero; same-cycle new alarms and events still set.
// - macro enable reads 0/1, enabled at power-up, clearing leaves running macros.
// - arguments accept 0x hex form; replies given in decimal.
// - service request when status byte and its enable share a set bit.
module aesr_status #(
  parameter int unsigned ALARM_W = aesr_pkg::ALARM_W
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [ALARM_W-1:0] alarm_trip,
  input wire logic panel_touch,
  input wire aesr_pkg::aesr_evt_in_t evt_in,
  input wire aesr_pkg::aesr_char_t arg_char,
  input wire aesr_pkg::aesr_cmd_t cmd,
  output logic cmd_ready,
  output aesr_pkg::aesr_reply_t reply,
  output logic [7:0] status_byte,
  output logic service_req,
  output logic macro_enable
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b100
  } aesr_state_t;

  // input synchronisers
  logic [ALARM_W-1:0] alarm_sync;
  logic panel_sync;
  logic panel_prev_reg;
  logic panel_event;

  aesr_sync #(
    .W(ALARM_W)
  ) u_alarm_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin_in(alarm_trip),
    .pin_sync(alarm_sync)
  );

  aesr_sync #(
    .W(1)
  ) u_panel_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin_in(panel_touch),
    .pin_sync(panel_sync)
  );

  // prior synced level, reset to the idle low so no false edge follows reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      panel_prev_reg <= 1'b0;
    end else begin
      panel_prev_reg <= panel_sync;
    end
  end

  assign panel_event = panel_sync & ~panel_prev_reg;

  // argument parser
  // a leading "0x" switches to hex nibbles, otherwise decimal digits
  logic [31:0] arg_reg, arg_next;
  logic hex_reg, hex_next;
  logic lead0_reg, lead0_next;
  logic [8:0] nchar_reg, nchar_next;
  logic take_cmd;

  function automatic logic [4:0] hex_digit(input logic [7:0] c);
    if (c >= aesr_pkg::CH_0 && c <= aesr_pkg::CH_9) hex_digit = {1'b1, 4'(c - aesr_pkg::CH_0)};
    else if (c >= aesr_pkg::CH_LA && c <= aesr_pkg::CH_LF) hex_digit = {1'b1, 4'(c - aesr_pkg::CH_LA + 8'h0A)};
    else if (c >= aesr_pkg::CH_UA && c <= aesr_pkg::CH_UF) hex_digit = {1'b1, 4'(c - aesr_pkg::CH_UA + 8'h0A)};
    else hex_digit = 5'h00;
  endfunction

  always_comb begin
    logic [4:0] hd;
    hd = hex_digit(arg_char.data);
    arg_next = arg_reg;
    hex_next = hex_reg;
    lead0_next = lead0_reg;
    nchar_next = nchar_reg;
    if (take_cmd) begin
      arg_next = '0;
      hex_next = 1'b0;
      lead0_next = 1'b0;
      nchar_next = '0;
    end else if (arg_char.valid && nchar_reg < 9'(aesr_pkg::ARG_MAX_CHARS)) begin
      nchar_next = nchar_reg + 9'h001;
      if (nchar_reg == 9'h000 && arg_char.data == aesr_pkg::CH_0) begin
        lead0_next = 1'b1;
      end else if (nchar_reg == 9'h001 && lead0_reg && arg_char.data == aesr_pkg::CH_X) begin
        hex_next = 1'b1;
      end else if (hex_reg && hd[4]) begin
        arg_next = {arg_reg[27:0], hd[3:0]};
      end else if (!hex_reg && arg_char.data >= aesr_pkg::CH_0 && arg_char.data <= aesr_pkg::CH_9) begin
        arg_next = 32'((arg_reg << 3) + (arg_reg << 1) + 32'(arg_char.data - aesr_pkg::CH_0));
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      arg_reg <= '0;
      hex_reg <= 1'b0;
      lead0_reg <= 1'b0;
      nchar_reg <= '0;
    end else begin
      arg_reg <= arg_next;
      hex_reg <= hex_next;
      lead0_reg <= lead0_next;
      nchar_reg <= nchar_next;
    end
  end

  // status registers
  logic [ALARM_W-1:0] alarm_latch_reg, alarm_latch_next;
  logic [ALARM_W-1:0] alarm_enable_mask_reg, alarm_enable_mask_next;
  logic [7:0] event_reg, event_next;
  logic [7:0] event_enable_reg, event_enable_next;
  logic [7:0] srq_enable_reg, srq_enable_next;
  logic macro_en_reg, macro_en_next;
  logic [7:0] evt_set;
  logic [31:0] read_val;
  logic read_req;
  logic stb_alarm, stb_evt;
  logic [7:0] srq_src;

  assign take_cmd = cmd.valid & cmd_ready;

  always_comb begin
    evt_set = 8'h00;
    evt_set[aesr_pkg::EVT_USR_BIT] = panel_event;
    evt_set[aesr_pkg::EVT_CMD_BIT] = evt_in.cmd_error;
    evt_set[aesr_pkg::EVT_EXE_BIT] = evt_in.exec_error;
    evt_set[aesr_pkg::EVT_OPC_BIT] = evt_in.op_complete;
  end

  // summary bits straight from present contents
  assign stb_alarm = |(alarm_latch_reg & alarm_enable_mask_reg);
  assign stb_evt = |(event_reg & event_enable_reg);

  always_comb begin
    status_byte = 8'h00;
    status_byte[aesr_pkg::STB_ALARM_BIT] = stb_alarm;
    status_byte[aesr_pkg::STB_EVT_BIT] = stb_evt;
    status_byte[aesr_pkg::STB_RQS_BIT] = service_req;
  end

  // status bits that may raise a request; bit 6 stays out to avoid a loop through itself
  always_comb begin
    srq_src = 8'h00;
    srq_src[aesr_pkg::STB_ALARM_BIT] = stb_alarm;
    srq_src[aesr_pkg::STB_EVT_BIT] = stb_evt;
  end

  assign service_req = |(srq_src & srq_enable_reg);
  assign macro_enable = macro_en_reg;

  always_comb begin
    alarm_latch_next = alarm_latch_reg;
    alarm_enable_mask_next = alarm_enable_mask_reg;
    event_next = event_reg;
    event_enable_next = event_enable_reg;
    srq_enable_next = srq_enable_reg;
    macro_en_next = macro_en_reg;
    read_val = '0;
    read_req = 1'b0;
    if (take_cmd) begin
      read_req = (cmd.op != aesr_pkg::OP_NOP) && (cmd.op != aesr_pkg::OP_CLEAR_STATUS)
        && (cmd.op != aesr_pkg::OP_SET_ALARM_EN) && (cmd.op != aesr_pkg::OP_SET_MACRO_EN)
        && (cmd.op != aesr_pkg::OP_SET_EVT_EN) && (cmd.op != aesr_pkg::OP_SET_SRQ_EN);
      case (cmd.op)
        aesr_pkg::OP_SET_ALARM_EN: alarm_enable_mask_next = ALARM_W'(arg_reg);
        aesr_pkg::OP_GET_ALARM_EN: read_val = 32'(alarm_enable_mask_reg);
        aesr_pkg::OP_GET_ALARM: begin
          read_val = 32'(alarm_latch_reg);
          alarm_latch_next = '0;
        end
        aesr_pkg::OP_CLEAR_STATUS: begin
          alarm_latch_next = '0;
          alarm_enable_mask_next = '0;
          event_next = 8'h00;
          event_enable_next = 8'h00;
          srq_enable_next = 8'h00;
        end
        aesr_pkg::OP_SET_MACRO_EN: macro_en_next = |arg_reg;
        aesr_pkg::OP_GET_MACRO_EN: read_val = {31'h0, macro_en_reg};
        aesr_pkg::OP_SET_EVT_EN: event_enable_next = arg_reg[7:0];
        aesr_pkg::OP_GET_EVT_EN: read_val = {24'h0, event_enable_reg};
        aesr_pkg::OP_GET_EVT: begin
          read_val = {24'h0, event_reg};
          event_next = 8'h00;
        end
        aesr_pkg::OP_SET_SRQ_EN: srq_enable_next = arg_reg[7:0];
        aesr_pkg::OP_GET_SRQ_EN: read_val = {24'h0, srq_enable_reg};
        aesr_pkg::OP_GET_STB: read_val = {24'h0, status_byte};
        default: read_val = '0;
      endcase
    end
    // new events win over a same-cycle clear
    alarm_latch_next = alarm_latch_next | alarm_sync;
    event_next = (event_next | evt_set) & aesr_pkg::EVT_LIVE_MASK;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_latch_reg <= ALARM_W'(aesr_pkg::ALARM_LATCH_RST);
      alarm_enable_mask_reg <= ALARM_W'(aesr_pkg::ALARM_MASK_RST);
      event_reg <= aesr_pkg::EVT_REG_RST;
      event_enable_reg <= aesr_pkg::EVT_EN_RST;
      srq_enable_reg <= aesr_pkg::SRQ_EN_RST;
      macro_en_reg <= aesr_pkg::EMC_RST;
    end else begin
      alarm_latch_reg <= alarm_latch_next;
      alarm_enable_mask_reg <= alarm_enable_mask_next;
      event_reg <= event_next;
      event_enable_reg <= event_enable_next;
      srq_enable_reg <= srq_enable_next;
      macro_en_reg <= macro_en_next;
    end
  end

  // binary to decimal reply, one bit per cycle
  aesr_state_t state_reg, state_next;
  logic [31:0] bin_reg, bin_next;
  logic [39:0] bcd_reg, bcd_next;
  logic [5:0] cnt_reg, cnt_next;
  aesr_pkg::aesr_reply_t reply_reg, reply_next;

  // every digit adjusted before the shift
  wire logic [39:0] adj;

  for (genvar g = 0; g < aesr_pkg::BCD_DIGITS; g++) begin : g_add3
    aesr_add3 u_aesr_add3 (
      .digit_in(bcd_reg[g*4 +: 4]),
      .digit_out(adj[g*4 +: 4])
    );
  end

  // queries and unlisted op codes leave idle, so ready falls for a whole reply conversion
  assign cmd_ready = (state_reg == ST_IDLE);

  always_comb begin
    state_next = state_reg;
    bin_next = bin_reg;
    bcd_next = bcd_reg;
    cnt_next = cnt_reg;
    reply_next = reply_reg;
    reply_next.valid = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (read_req) begin
          bin_next = read_val;
          bcd_next = '0;
          cnt_next = '0;
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        bcd_next = {adj[38:0], bin_reg[31]};
        bin_next = {bin_reg[30:0], 1'b0};
        cnt_next = cnt_reg + 6'h01;
        if (cnt_reg == 6'(aesr_pkg::CONV_CYCLES - 1)) state_next = ST_DONE;
      end
      ST_DONE: begin
        reply_next.valid = 1'b1;
        reply_next.bcd = bcd_reg;
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      bin_reg <= '0;
      bcd_reg <= '0;
      cnt_reg <= '0;
      reply_reg <= '0;
    end else begin
      state_reg <= state_next;
      bin_reg <= bin_next;
      bcd_reg <= bcd_next;
      cnt_reg <= cnt_next;
      reply_reg <= reply_next;
    end
  end

  assign reply = reply_reg;

endmodule // aesr_status

// two flip-flops for levels from outside the clock domain
module aesr_sync #(
  parameter int unsigned W = 1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);

  logic [W-1:0] s1_reg, s2_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
    end
  end

  assign pin_sync = s2_reg;

endmodule // aesr_sync

// one decimal digit of the shift-and-add-3 step
module aesr_add3 (
  input wire logic [3:0] digit_in,
  output logic [3:0] digit_out
);

  assign digit_out = (digit_in >= 4'h5) ? digit_in + 4'h3 : digit_in;

endmodule // aesr_add3

/* include/aesr_pkg.sv */
// package for the alarm and event status reporting block
// assumes one 25 MHz clock domain, sys_clk, with async active-low reset
package aesr_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned ALARM_W = 32;
  localparam int unsigned EVT_W = 8;
  localparam int unsigned BCD_DIGITS = 10;
  localparam int unsigned CONV_CYCLES = 32;

  // standard event bit positions
  localparam int unsigned EVT_OPC_BIT = 0;
  localparam int unsigned EVT_EXE_BIT = 4;
  localparam int unsigned EVT_CMD_BIT = 5;
  localparam int unsigned EVT_USR_BIT = 6;
  localparam int unsigned EVT_PON_BIT = 7;
  localparam logic [7:0] EVT_LIVE_MASK = 8'hF1;

  // status byte bit positions
  localparam int unsigned STB_ALARM_BIT = 0;
  localparam int unsigned STB_EVT_BIT = 5;
  localparam int unsigned STB_RQS_BIT = 6;

  // values after reset
  localparam logic [31:0] ALARM_LATCH_RST = 32'h0000_0000;
  localparam logic [31:0] ALARM_MASK_RST = 32'h0000_0000;
  localparam logic [7:0] EVT_REG_RST = 8'h80;
  localparam logic [7:0] EVT_EN_RST = 8'h00;
  localparam logic [7:0] SRQ_EN_RST = 8'h00;
  localparam logic EMC_RST = 1'b1;

  // argument characters
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_X = 8'h78;
  localparam logic [7:0] CH_UA = 8'h41;
  localparam logic [7:0] CH_UF = 8'h46;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LF = 8'h66;
  localparam int unsigned ARG_MAX_CHARS = 256;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_SET_ALARM_EN = 4'h1,
    OP_GET_ALARM_EN = 4'h2,
    OP_GET_ALARM = 4'h3,
    OP_CLEAR_STATUS = 4'h4,
    OP_SET_MACRO_EN = 4'h5,
    OP_GET_MACRO_EN = 4'h6,
    OP_SET_EVT_EN = 4'h7,
    OP_GET_EVT_EN = 4'h8,
    OP_GET_EVT = 4'h9,
    OP_SET_SRQ_EN = 4'hA,
    OP_GET_SRQ_EN = 4'hB,
    OP_GET_STB = 4'hC
  } aesr_op_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } aesr_char_t;

  typedef struct packed {
    logic valid;
    aesr_op_t op;
  } aesr_cmd_t;

  typedef struct packed {
    logic valid;
    logic [39:0] bcd;
  } aesr_reply_t;

  typedef struct packed {
    logic cmd_error;
    logic exec_error;
    logic op_complete;
  } aesr_evt_in_t;

endpackage

/* verif/aesr_host_model.sv */
// host model: types an argument, then issues one command
// assumes the block's clock; outputs read mid-cycle
module aesr_host_model (
  input wire logic sys_clk,
  input wire logic cmd_ready,
  input wire aesr_pkg::aesr_reply_t reply,
  output aesr_pkg::aesr_char_t arg_char,
  output aesr_pkg::aesr_cmd_t cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    arg_char = '0;
    cmd = '0;
  end
  // one char, sometimes followed by an idle cycle
  task automatic put(input logic [7:0] c);
    @(posedge sys_clk);
    arg_char <= '{1'b1, c};
    if ($urandom % 2 == 1) begin
      @(posedge sys_clk);
      arg_char <= '{1'b0, ~c};
    end
  endtask
  task automatic run(input logic [3:0] op, input logic [31:0] v, input bit hx,
                     output logic [39:0] r, output bit to);
    bit q;
    q = op inside {4'h2, 4'h3, 4'h6, 4'h8, 4'h9, 4'hB, 4'hC};
    if (hx) begin
      put(8'h30);
      put(8'h78);
    end
    for (int i = hx ? 7 : 9; i >= 0; i--) begin
      put(hx ? (v[4*i+:4] > 4'h9 ? ($urandom % 2 == 1 ? 8'h37 : 8'h57) : 8'h30) + v[4*i+:4]
        : 8'h30 + 8'((v / 10 ** i) % 10));
    end
    @(posedge sys_clk);
    arg_char.valid <= 1'b0;
    cmd <= '{1'b1, aesr_pkg::aesr_op_t'(op)};
    to = 1'b1;
    for (int n = 0; n < 40 && to; n++) begin
      @(negedge sys_clk);
      to = !cmd_ready;
      @(posedge sys_clk);
    end
    cmd <= '{1'b0, aesr_pkg::aesr_op_t'(~op)};
    r = '0;
    for (int n = 0; n < 40 && q && !to; n++) begin
      @(negedge sys_clk);
      q = !reply.valid;
      r = reply.bcd;
      to = q && n == 39;
    end
    @(posedge sys_clk);
  endtask
endmodule // aesr_host_model

/* verif/aesr_status_checker.sv */
// port checker for the status reporting block
// assumes it is bound to aesr_status, one clock domain
module aesr_status_checker (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire aesr_pkg::aesr_cmd_t cmd,
  input wire logic cmd_ready,
  input wire aesr_pkg::aesr_reply_t reply,
  input wire logic [7:0] status_byte,
  input wire logic service_req,
  input wire logic macro_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  wire tk = cmd.valid && cmd_ready;
  wire [3:0] op = cmd.op;
  wire qry = tk && op inside {4'h2, 4'h3, 4'h6, 4'h8, 4'h9, 4'hB, 4'hC};
  wire emc_set = tk && op == 4'h5;
  wire alarm_drop = tk && op inside {4'h1, 4'h3, 4'h4};
  wire evt_drop = tk && op inside {4'h4, 4'h7, 4'h9};
  reply_pulse_a: assert property (reply.valid |=> !reply.valid)
    else $error("reply longer than one cycle");
  ready_low_a: assert property (qry |=> !cmd_ready [*8])
    else $error("ready during query");
  reply_time_a: assert property (qry |-> ##34 reply.valid)
    else $error("reply not on time");
  clear_all_a: assert property (tk && op == 4'h4 |=> status_byte == 8'h00)
    else $error("status after clear");
  srq_bit_a: assert property (status_byte[6] == service_req
    && (!service_req || status_byte[0] || status_byte[5]))
    else $error("service bit");
  spare_bits_a: assert property ((status_byte & 8'h9E) == 8'h00)
    else $error("spare status bits");
  emc_reset_a: assert property ($rose(rst_b) |-> macro_enable)
    else $error("macro enable at reset");
  emc_hold_a: assert property ($changed(macro_enable) |-> $past(emc_set))
    else $error("macro enable moved");
  alarm_hold_a: assert property ($fell(status_byte[0]) |-> $past(alarm_drop))
    else $error("alarm summary fell");
  event_hold_a: assert property ($fell(status_byte[5]) |-> $past(evt_drop))
    else $error("event summary fell");
endmodule // aesr_status_checker
bind aesr_status aesr_status_checker u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .cmd(cmd), .cmd_ready(cmd_ready),
  .reply(reply), .status_byte(status_byte), .service_req(service_req), .macro_enable(macro_enable));

/* verif/alarm_event_status_reporting_tb_top.sv */
// self-checking bench: host model sends commands, bench drives pins
// assumes package, design, checker and host model compiled first
module alarm_event_status_reporting_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] alarm_trip = '0;
  logic panel_touch = 1'b0;
  aesr_pkg::aesr_evt_in_t evt_in = '0;
  aesr_pkg::aesr_char_t arg_char;
  aesr_pkg::aesr_cmd_t cmd;
  aesr_pkg::aesr_reply_t reply;
  logic cmd_ready;
  logic service_req;
  logic macro_enable;
  logic [7:0] status_byte;
  logic [39:0] r;
  logic [31:0] m;
  bit to;
  int n_errors = 0;
  int n_compared = 0;
  aesr_status u_aesr_status (.sys_clk(sys_clk), .rst_b(rst_b), .alarm_trip(alarm_trip), .panel_touch(panel_touch),
    .evt_in(evt_in), .arg_char(arg_char), .cmd(cmd), .cmd_ready(cmd_ready), .reply(reply),
    .status_byte(status_byte), .service_req(service_req), .macro_enable(macro_enable));
  aesr_host_model u_aesr_host_model (.sys_clk(sys_clk), .cmd_ready(cmd_ready), .reply(reply),
    .arg_char(arg_char), .cmd(cmd));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [39:0] bcd(input logic [31:0] v);
    for (int i = 0; i < 10; i++) begin
      bcd[4*i+:4] = 4'((v / 10 ** i) % 10);
    end
  endfunction
  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    if (n_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic q(input logic [3:0] op, input logic [31:0] v, input bit hx);
    u_aesr_host_model.run(op, v, hx, r, to);
    if (to) begin
      n_errors++;
      end_sim();
    end
  endtask
  // 0..2 one-cycle event pulse, 3 panel press
  task automatic pulse(input int i);
    @(posedge sys_clk);
    evt_in <= 3'(i < 3 ? 1 << i : 0);
    panel_touch <= i == 3;
    @(posedge sys_clk);
    evt_in <= '0;
    @(posedge sys_clk);
    panel_touch <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
  initial begin
    m = $urandom(32'hE4E38356);
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    q(4'h9, 0, 0);
    chk(r, bcd(128));
    q(4'h9, 0, 0);
    chk(r, 40'h0);
    q(4'h6, 0, 0);
    chk(r, bcd(1));
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      q(4'h9, 0, 0);
      chk(r, bcd(i == 0 ? 1 : 8 << i));
    end
    for (int k = 0; k < 4; k++) begin
      m = $urandom;
      m[k * 7] = k[0];
      q(4'h1, m, k[1]);
      @(posedge sys_clk);
      alarm_trip <= 32'h1 << (k * 7);
      repeat (2) @(posedge sys_clk);
      alarm_trip <= '0;
      repeat (6) @(posedge sys_clk);
      chk(status_byte[0], k[0]);
      q(4'h2, 0, 0);
      chk(r, bcd(m));
      q(4'h3, 0, 0);
      chk(r, bcd(32'h1 << (k * 7)));
      q(4'h3, 0, 0);
      chk(r, 40'h0);
    end
    q(4'h7, 32'h40, 1);
    pulse(3);
    chk(status_byte[5], 1'b1);
    q(4'hA, 32'h20, 0);
    @(posedge sys_clk);
    chk(service_req, 1'b1);
    q(4'hB, 0, 0);
    chk(r, bcd(32));
    q(4'hC, 0, 0);
    chk(r, bcd(96));
    q(4'h0, 32'h55, 1);
    chk(status_byte, 8'h60);
    q(4'h4, 0, 0);
    chk(status_byte, 8'h00);
    q(4'h8, 0, 0);
    chk(r, 40'h0);
    q(4'h5, 0, 0);
    chk(macro_enable, 1'b0);
    q(4'h6, 0, 0);
    chk(r, 40'h0);
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    q(4'h9, 0, 0);
    chk(r, bcd(128));
    chk(macro_enable, 1'b1);
    end_sim();
  end
endmodule // alarm_event_status_reporting_tb_top
